//--- hdl/pbvto_core.sv
// forwarding control of a two-bus bridge: vga decode, palette snoop, timers, ordering
// assumes address-phase, grant and data-phase events arrive synchronous to sys_clk_i;
// index 0 is the primary bus, 1 the secondary; the initiator side i targets bus 1-i
//
// Local design decisions: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none

module pbvto_core
  import pbvto_pkg::*;
#(
  parameter int DATA_W = 32
)(
  input  wire logic                   sys_clk_i,
  input  wire logic                   resetn_i,
  input  wire logic [7:0]             reg_addr_i,
  input  wire logic [31:0]            reg_wdata_i,
  input  wire logic                   reg_wr_i,
  input  wire logic                   reg_rd_i,
  output logic      [31:0]            reg_rdata_o,
  input  wire logic [1:0]             req_start_i,
  input  wire logic [1:0][31:0]       req_addr_i,
  input  wire logic [1:0]             req_io_i,
  input  wire logic [1:0]             req_write_i,
  input  wire logic [1:0]             req_post_i,
  input  wire logic [1:0]             req_mwi_i,
  input  wire logic                   req_own_cfg_i,
  input  wire logic [1:0]             base_limit_hit_i,
  input  wire logic [1:0]             xfer_done_i,
  input  wire logic [1:0]             tgt_gnt_i,
  input  wire logic [1:0]             tgt_started_i,
  input  wire logic [1:0]             tgt_data_phase_i,
  input  wire logic [1:0]             tgt_xfer_i,
  input  wire logic [1:0]             line_boundary_i,
  input  wire logic [1:0]             ini_last_dword_i,
  input  wire logic [1:0]             ini_end_i,
  input  wire logic [1:0]             wbuf_full_i,
  input  wire logic [1:0]             tgt_idle_i,
  input  wire logic [1:0]             dat_valid_i,
  input  wire logic [1:0][DATA_W-1:0] dat_i,
  input  wire logic [1:0][3:0]        be_i,
  output logic      [1:0]             fwd_o,
  output logic      [1:0]             retry_o,
  output logic      [1:0]             disc_o,
  output logic      [1:0]             tgt_req_o,
  output logic      [1:0]             frame_drop_o,
  output logic      [1:0]             dat_valid_o,
  output logic      [1:0][DATA_W-1:0] dat_o,
  output logic      [1:0][3:0]        be_o
);

  // the decode and the data path are fixed at 32 bits
  if (DATA_W != 32)
  begin
    $error("pbvto_core serves 32-bit buses only");
  end

  logic            rst_meta_q;
  logic            rst_sync_q;
  pbvto_state_type s_q;
  pbvto_state_type s_d;

  always_ff @(posedge sys_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  function automatic logic vga_io_hit(input logic [31:0] a);
    // bits 15:10 are ignored so every 1K alias matches
    vga_io_hit = (a[31:16] == 16'h0000)
               && (a[9:0] >= `PBVTO_VGA_IO_LO) && (a[9:0] <= `PBVTO_VGA_IO_HI)
               && !((a[9:0] >= `PBVTO_PRN_LO) && (a[9:0] <= `PBVTO_PRN_HI));
  endfunction

  function automatic logic pal_hit(input logic [31:0] a);
    pal_hit = (a[31:16] == 16'h0000)
            && ((a[9:0] == `PBVTO_PAL_A) || (a[9:0] == `PBVTO_PAL_B)
            || (a[9:0] == `PBVTO_PAL_C));
  endfunction

  function automatic logic fb_hit(input logic [31:0] a);
    fb_hit = (a >= `PBVTO_FB_LO) && (a <= `PBVTO_FB_HI);
  endfunction

  // wants to cross from side sd; base_hit already means "forward from this side"
  function automatic logic cross_want(input logic sd, input logic [31:0] a, input logic io,
                                      input logic wr, input logic base_hit,
                                      input logic [2:0] c);
    logic vhit;
    vhit = io ? vga_io_hit(a) : fb_hit(a);
    if (c[`PBVTO_CTRL_VGA] && vhit)
      cross_want = !sd;
    else if (c[`PBVTO_CTRL_SNOOP] && !c[`PBVTO_CTRL_VGA] && io && pal_hit(a))
      cross_want = sd ? !wr : wr;
    else if (io && c[`PBVTO_CTRL_LEGACY] && (a[9:8] != 2'b00))
      cross_want = sd;
    else
      cross_want = base_hit;
  endfunction

  logic [1:0] want;
  always_comb
  begin
    for (int i = 0; i < 2; i++)
      want[i] = cross_want(i[0], req_addr_i[i], req_io_i[i], req_write_i[i],
                           base_limit_hit_i[i], s_q.ctrl);
  end

  always_comb
  begin
    int         j;
    logic [1:0] take;
    logic [1:0] twt_exp;
    logic       own_ok;
    s_d        = s_q;
    take       = 2'b00;
    twt_exp    = 2'b00;
    j          = 0;
    own_ok     = 1'b0;
    s_d.fwd        = 2'b00;
    s_d.retry      = 2'b00;
    s_d.disc       = 2'b00;
    s_d.frame_drop = 2'b00;
    s_d.rdata      = 32'h00000000;

    if (reg_wr_i)
    begin
      if (reg_addr_i == `PBVTO_REG_CTRL)
        s_d.ctrl = reg_wdata_i[2:0];
      else if (reg_addr_i == `PBVTO_REG_PLAT)
        s_d.lat_lim[0] = reg_wdata_i[7:0];
      else if (reg_addr_i == `PBVTO_REG_SLAT)
        s_d.lat_lim[1] = reg_wdata_i[7:0];
      else if (reg_addr_i == `PBVTO_REG_PTWT)
        s_d.twt_lim[0] = reg_wdata_i[7:0];
      else if (reg_addr_i == `PBVTO_REG_STWT)
        s_d.twt_lim[1] = reg_wdata_i[7:0];
      else if (reg_addr_i == `PBVTO_REG_BURST)
        // values of bits 6:0 above 64 are clipped to the largest legal limit
        s_d.burst_lim = (reg_wdata_i[6:0] > `PBVTO_BURST_MAX) ? `PBVTO_BURST_MAX
                                                              : reg_wdata_i[6:0];
    end
    if (reg_rd_i)
    begin
      if (reg_addr_i == `PBVTO_REG_CTRL)
        s_d.rdata = {29'h0, s_q.ctrl};
      else if (reg_addr_i == `PBVTO_REG_PLAT)
        s_d.rdata = {24'h0, s_q.lat_lim[0]};
      else if (reg_addr_i == `PBVTO_REG_SLAT)
        s_d.rdata = {24'h0, s_q.lat_lim[1]};
      else if (reg_addr_i == `PBVTO_REG_PTWT)
        s_d.rdata = {24'h0, s_q.twt_lim[0]};
      else if (reg_addr_i == `PBVTO_REG_STWT)
        s_d.rdata = {24'h0, s_q.twt_lim[1]};
      else if (reg_addr_i == `PBVTO_REG_BURST)
        s_d.rdata = {25'h0, s_q.burst_lim};
      else if (reg_addr_i == `PBVTO_REG_STATUS)
        s_d.rdata = {22'h0, s_q.lt_term, s_q.started, s_q.tgt_req, s_q.posted, s_q.busy};
    end

    // ordering: a crossing is refused while the other side holds anything but a
    // posted write against a posted write; the primary wins same-cycle ties unless both are posted writes, which both cross
    for (int i = 0; i < 2; i++)
    begin
      j = 1 - i;
      // an access to our own config space never crosses, so it takes no crossing slot
      if (req_start_i[i] && want[i] && !(i == 0 && req_own_cfg_i))
      begin
        if (s_q.busy[i])
          s_d.retry[i] = 1'b1;
        else if (s_q.busy[j] && !(s_q.posted[j] && req_post_i[i]))
          s_d.retry[i] = 1'b1;
        else if (i == 1 && take[0] && !(req_post_i[0] && req_post_i[1]))
          s_d.retry[i] = 1'b1;
        else
          take[i] = 1'b1;
      end
    end
    // own config space stays reachable behind upstream posted writes
    own_ok = !s_q.busy[0] && (!s_q.busy[1] || s_q.posted[1]) && !take[0];
    if (req_start_i[0] && req_own_cfg_i)
    begin
      if (own_ok)
        s_d.fwd[0] = 1'b1;
      else
        s_d.retry[0] = 1'b1;
    end

    for (int i = 0; i < 2; i++)
    begin
      j = 1 - i;
      twt_exp[i] = (s_q.twt_lim[i] != 8'h00) && (s_q.twt_cnt[i] >= s_q.twt_lim[i]);
      if (s_q.busy[i])
      begin
        if (!s_q.started[i] && !s_q.posted[i])
        begin
          if (!twt_exp[i])
            s_d.twt_cnt[i] = s_q.twt_cnt[i] + 8'h01;
          if (twt_exp[i] && !tgt_gnt_i[j])
          begin
            s_d.retry[i]   = 1'b1;
            s_d.tgt_req[j] = 1'b0;
            s_d.busy[i]    = 1'b0;
          end
        end
        if (tgt_started_i[j])
        begin
          s_d.started[i] = 1'b1;
          s_d.tgt_req[j] = 1'b0;
        end
        if ((s_q.lt_term[i] && s_q.isread[i] && ini_last_dword_i[i])
            || (s_q.lt_term[i] && s_q.posted[i] && wbuf_full_i[i]))
          s_d.disc[i] = 1'b1;
        if (s_q.posted[i] && wbuf_full_i[i] && !tgt_idle_i[j])
          s_d.disc[i] = 1'b1;
        if (xfer_done_i[i])
          s_d.busy[i] = 1'b0;
      end
      if (take[i])
      begin
        s_d.fwd[i]     = 1'b1;
        s_d.busy[i]    = 1'b1;
        s_d.posted[i]  = req_post_i[i];
        s_d.isread[i]  = !req_write_i[i];
        s_d.ismwi[i]   = req_mwi_i[i];
        s_d.started[i] = 1'b0;
        s_d.lt_term[i] = 1'b0;
        s_d.twt_cnt[i] = 8'h00;
        s_d.tgt_req[j] = 1'b1;
        s_d.bcnt[i]    = 7'h00;
        s_d.pf_on[i]   = 1'b0;
        s_d.pf_cnt[i]  = 3'h0;
      end
    end

    // master side on bus j serves initiator side i
    for (int i = 0; i < 2; i++)
    begin
      j = 1 - i;
      if (tgt_started_i[j])
      begin
        s_d.mlt_run[j] = 1'b1;
        s_d.mlt_cnt[j] = 8'h00;
      end
      else if (s_q.mlt_run[j] && s_q.mlt_cnt[j] < s_q.lat_lim[j])
        s_d.mlt_cnt[j] = s_q.mlt_cnt[j] + 8'h01;
      if (s_q.mlt_run[j] && s_q.busy[i])
      begin
        if (s_q.ismwi[i])
        begin
          if (line_boundary_i[j])
          begin
            s_d.frame_drop[j] = 1'b1;
            s_d.mlt_run[j]    = 1'b0;
          end
        end
        else if (s_q.mlt_cnt[j] >= s_q.lat_lim[j] && !tgt_gnt_i[j] && tgt_data_phase_i[j])
        begin
          s_d.frame_drop[j] = 1'b1;
          s_d.lt_term[i]    = 1'b1;
          s_d.mlt_run[j]    = 1'b0;
        end
        if (tgt_xfer_i[j])
        begin
          s_d.bcnt[i] = s_q.bcnt[i] + 7'h01;
          if (s_q.burst_lim != 7'h00 && s_q.bcnt[i] + 7'h01 == s_q.burst_lim)
          begin
            s_d.frame_drop[j] = 1'b1;
            s_d.disc[i]       = 1'b1;
            s_d.mlt_run[j]    = 1'b0;
          end
        end
        // prefetch runs on for a bounded number of reads once the initiator stops
        if (s_q.isread[i] && ini_end_i[i])
          s_d.pf_on[i] = 1'b1;
        if (s_q.pf_on[i] && tgt_xfer_i[j])
        begin
          s_d.pf_cnt[i] = s_q.pf_cnt[i] + 3'h1;
          if (s_q.pf_cnt[i] + 3'h1 == `PBVTO_PF_EXTRA)
          begin
            s_d.frame_drop[j] = 1'b1;
            s_d.mlt_run[j]    = 1'b0;
          end
        end
      end
      if (xfer_done_i[i])
        s_d.mlt_run[j] = 1'b0;
    end

    // two-stage data path, byte enables carried untouched beside the data
    for (int i = 0; i < 2; i++)
    begin
      j = 1 - i;
      s_d.dpipe[j][0]  = dat_i[i];
      s_d.dpipe[j][1]  = s_q.dpipe[j][0];
      s_d.bepipe[j][0] = be_i[i];
      s_d.bepipe[j][1] = s_q.bepipe[j][0];
      s_d.vpipe[j][0]  = dat_valid_i[i];
      s_d.vpipe[j][1]  = s_q.vpipe[j][0];
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_sync_q)
  begin
    if (!rst_sync_q)
    begin
      s_q           <= '0;
      s_q.ctrl      <= `PBVTO_CTRL_RST;
      s_q.lat_lim   <= {`PBVTO_LAT_RST, `PBVTO_LAT_RST};
      s_q.twt_lim   <= {`PBVTO_TWT_RST, `PBVTO_TWT_RST};
      s_q.burst_lim <= `PBVTO_BURST_RST;
    end
    else
      s_q <= s_d;
  end

  assign reg_rdata_o  = s_q.rdata;
  assign fwd_o        = s_q.fwd;
  assign retry_o      = s_q.retry;
  assign disc_o       = s_q.disc;
  assign tgt_req_o    = s_q.tgt_req;
  assign frame_drop_o = s_q.frame_drop;
  always_comb
  begin
    for (int k = 0; k < 2; k++)
    begin
      dat_valid_o[k] = s_q.vpipe[k][1];
      dat_o[k]       = s_q.dpipe[k][1];
      be_o[k]        = s_q.bepipe[k][1];
    end
  end

  // checks
  property p_vga_down;
    @(posedge sys_clk_i) disable iff (!rst_sync_q)
    req_start_i[0] && req_io_i[0] && s_q.ctrl[`PBVTO_CTRL_VGA] && vga_io_hit(req_addr_i[0])
    |=> (fwd_o[0] || retry_o[0]);
  endproperty
  a_vga_down: assert property (p_vga_down) else $error("vga io not forwarded");

  property p_vga_up_ignored;
    @(posedge sys_clk_i) disable iff (!rst_sync_q)
    req_start_i[1] && req_io_i[1] && s_q.ctrl[`PBVTO_CTRL_VGA] && vga_io_hit(req_addr_i[1])
    && !s_q.busy[1] |=> !fwd_o[1] && !retry_o[1];
  endproperty
  a_vga_up_ignored: assert property (p_vga_up_ignored) else $error("vga io claimed upstream");

  property p_legacy_block;
    @(posedge sys_clk_i) disable iff (!rst_sync_q)
    req_start_i[0] && req_io_i[0] && !s_q.ctrl[`PBVTO_CTRL_VGA] && !s_q.ctrl[`PBVTO_CTRL_SNOOP]
    && s_q.ctrl[`PBVTO_CTRL_LEGACY] && vga_io_hit(req_addr_i[0]) && !req_own_cfg_i
    |=> !fwd_o[0];
  endproperty
  a_legacy_block: assert property (p_legacy_block) else $error("filtered vga io forwarded");

  property p_pal_read_ignored;
    @(posedge sys_clk_i) disable iff (!rst_sync_q)
    req_start_i[0] && req_io_i[0] && !req_write_i[0] && !req_own_cfg_i && pal_hit(req_addr_i[0])
    && s_q.ctrl[`PBVTO_CTRL_SNOOP] && !s_q.ctrl[`PBVTO_CTRL_VGA] |=> !fwd_o[0];
  endproperty
  a_pal_read_ignored: assert property (p_pal_read_ignored) else $error("palette read forwarded");

  property p_tie;
    @(posedge sys_clk_i) disable iff (!rst_sync_q)
    (&req_start_i) && (&want) && !(&req_post_i) && !(|s_q.busy) && !req_own_cfg_i
    |=> fwd_o[0] && retry_o[1];
  endproperty
  a_tie: assert property (p_tie) else $error("tie not resolved to primary");

  property p_pending_retry;
    @(posedge sys_clk_i) disable iff (!rst_sync_q)
    s_q.busy[0] && !s_q.posted[0] && req_start_i[1] && want[1] |=> retry_o[1] && !fwd_o[1];
  endproperty
  a_pending_retry: assert property (p_pending_retry) else $error("opposite crossing let in");

  property p_data_lat;
    @(posedge sys_clk_i) disable iff (!rst_sync_q)
    dat_valid_i[0] |-> ##2 dat_valid_o[1] && dat_o[1] == $past(dat_i[0], 2)
    && be_o[1] == $past(be_i[0], 2);
  endproperty
  a_data_lat: assert property (p_data_lat) else $error("data not two clocks later");

  property p_twt_retry;
    @(posedge sys_clk_i) disable iff (!rst_sync_q)
    s_q.busy[0] && !s_q.started[0] && !s_q.posted[0] && s_q.twt_lim[0] != 8'h00
    && s_q.twt_cnt[0] >= s_q.twt_lim[0] && !tgt_gnt_i[1] && !tgt_started_i[1]
    |=> retry_o[0] && !tgt_req_o[1] && !s_q.busy[0];
  endproperty
  a_twt_retry: assert property (p_twt_retry) else $error("wait timer did not retry");

  property p_twt_off;
    @(posedge sys_clk_i) disable iff (!rst_sync_q)
    s_q.twt_lim[0] == 8'h00 && s_q.busy[0] && !req_start_i[0] |=> !retry_o[0];
  endproperty
  a_twt_off: assert property (p_twt_off) else $error("disabled wait timer fired");

  c_vga_fwd: cover property (@(posedge sys_clk_i) disable iff (!rst_sync_q)
    req_start_i[0] && s_q.ctrl[`PBVTO_CTRL_VGA] ##1 fwd_o[0]);
  c_tie: cover property (@(posedge sys_clk_i) disable iff (!rst_sync_q)
    (&req_start_i) ##1 retry_o[1]);
  c_burst: cover property (@(posedge sys_clk_i) disable iff (!rst_sync_q)
    s_q.burst_lim != 7'h00 && disc_o[0] && frame_drop_o[1]);
  c_posted_both: cover property (@(posedge sys_clk_i) disable iff (!rst_sync_q)
    s_q.busy[0] && s_q.busy[1]);

endmodule

`default_nettype wire

//--- shared/pbvto_defines.svh
// constants for the bridge forwarding-control block: register map, fields, windows
// assumes inclusion by bare name from the package, which makes the constants visible to the core
`ifndef PBVTO_DEFINES_SVH
`define PBVTO_DEFINES_SVH

`define PBVTO_REG_CTRL      8'h00
`define PBVTO_REG_PLAT      8'h04
`define PBVTO_REG_SLAT      8'h08
`define PBVTO_REG_PTWT      8'h0c
`define PBVTO_REG_STWT      8'h10
`define PBVTO_REG_BURST     8'h14
`define PBVTO_REG_STATUS    8'h18

`define PBVTO_CTRL_VGA      0
`define PBVTO_CTRL_SNOOP    1
`define PBVTO_CTRL_LEGACY   2

`define PBVTO_CTRL_RST      3'h0
`define PBVTO_LAT_RST       8'h00
`define PBVTO_TWT_RST       8'h00
`define PBVTO_BURST_RST     7'h00
`define PBVTO_BURST_MAX     7'h40

`define PBVTO_VGA_IO_LO     10'h3b0
`define PBVTO_VGA_IO_HI     10'h3df
`define PBVTO_PRN_LO        10'h3bc
`define PBVTO_PRN_HI        10'h3bf
`define PBVTO_PAL_A         10'h3c6
`define PBVTO_PAL_B         10'h3c8
`define PBVTO_PAL_C         10'h3c9
`define PBVTO_FB_LO         32'h000a0000
`define PBVTO_FB_HI         32'h000bffff

`define PBVTO_DATA_LAT      2
`define PBVTO_PF_EXTRA      3'h4

`endif

//--- shared/pbvto_pkg.sv
// types for the bridge forwarding-control block
// assumes the defines header is on the include path
package pbvto_pkg;
  `include "pbvto_defines.svh"

  typedef struct packed {
    logic [2:0]             ctrl;
    logic [1:0][7:0]        lat_lim;
    logic [1:0][7:0]        twt_lim;
    logic [6:0]             burst_lim;
    logic [1:0]             busy;
    logic [1:0]             posted;
    logic [1:0]             isread;
    logic [1:0]             ismwi;
    logic [1:0]             started;
    logic [1:0]             lt_term;
    logic [1:0][7:0]        twt_cnt;
    logic [1:0][7:0]        mlt_cnt;
    logic [1:0]             mlt_run;
    logic [1:0][6:0]        bcnt;
    logic [1:0][2:0]        pf_cnt;
    logic [1:0]             pf_on;
    logic [1:0]             fwd;
    logic [1:0]             retry;
    logic [1:0]             disc;
    logic [1:0]             frame_drop;
    logic [1:0]             tgt_req;
    logic [1:0][1:0][31:0]  dpipe;
    logic [1:0][1:0][3:0]   bepipe;
    logic [1:0][1:0]        vpipe;
    logic [31:0]            rdata;
  } pbvto_state_type;
endpackage

//--- tb/pbvto_far.sv
// far-bus model: arbiter and target on both buses facing the forwarding core
// assumes the core holds its bus request until it sees its frame start
`timescale 1ns/1ns
`default_nettype none
module pbvto_far
(
  input  wire logic       sys_clk_i,
  input  wire logic       resetn_i,
  input  wire logic [1:0] req_i,
  input  wire logic [1:0] stall_i,
  output logic      [1:0] gnt_o,
  output logic      [1:0] started_o,
  output logic      [1:0] phase_o,
  output logic      [1:0] xfer_o,
  output logic      [1:0] line_o,
  output logic      [1:0] idle_o
);
  logic [1:0][2:0] cnt_q;
  // every data phase transfers, so extra prefetch reads are simply absorbed
  assign xfer_o = phase_o;
  assign idle_o = ~phase_o;
  always_comb
    for (int k = 0; k < 2; k++)
      line_o[k] = phase_o[k] && cnt_q[k][1:0] == 2'h3;
  always_ff @(posedge sys_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      gnt_o <= '0;
      started_o <= '0;
      phase_o <= '0;
      cnt_q <= '0;
    end
    else
      for (int k = 0; k < 2; k++)
      begin
        gnt_o[k] <= (req_i[k] || phase_o[k]) && !stall_i[k];
        started_o[k] <= gnt_o[k] && req_i[k] && !phase_o[k] && !started_o[k];
        cnt_q[k] <= phase_o[k] ? cnt_q[k] + 3'h1 : 3'h0;
        if (started_o[k])
          phase_o[k] <= 1'b1;
        else if (cnt_q[k] == 3'h7)
          phase_o[k] <= 1'b0;
      end
  end
endmodule
`default_nettype wire

//--- tb/test_pbvto_core.sv
// bench of the forwarding core: registers, decode, data path, timers, ordering
// assumes the far-bus model answers every bus request of the core unless its stall input holds that bus
`timescale 1ns/1ns
`default_nettype none
module test_pbvto_core;
  import pbvto_pkg::*;
  typedef struct packed {
    logic [6:0]  k;
    logic [31:0] a;
    logic        f;
  } pbvto_case_type;
  logic             sys_clk_i = 1'b0;
  logic             resetn_i = 1'b0;
  logic [7:0]       reg_addr_i = '0;
  logic [31:0]      reg_wdata_i = '0, reg_rdata_o, v;
  logic             reg_wr_i = 1'b0, reg_rd_i = 1'b0, req_own_cfg_i = 1'b0, rd_d = 1'b0, st_d = 1'b0;
  logic [1:0]       req_start_i = '0, req_io_i = '0, req_write_i = '0, req_post_i = '0, m;
  logic [1:0]       req_mwi_i = '0, base_limit_hit_i = '0, xfer_done_i = '0, stall = '0;
  logic [1:0]       line_boundary_i, ini_last_dword_i = '0, ini_end_i = '0, wbuf_full_i = '0;
  logic [1:0]       tgt_gnt_i, tgt_started_i, tgt_data_phase_i, tgt_xfer_i, tgt_idle_i;
  logic [1:0]       dat_valid_i = '0, fwd_o, retry_o, disc_o, tgt_req_o, frame_drop_o, dat_valid_o;
  logic [1:0][31:0] req_addr_i = '0, dat_i = '0, dat_o;
  logic [1:0][3:0]  be_i = '0, be_o;
  logic [3:0]       b, sq[$];
  logic [2:0]       seen3;
  logic [35:0]      dq[$], eq[$];
  logic [31:0]      rq[$];
  int               n_errors = 0, n_checks = 0, seed = 32'h71e52d1a;
  pbvto_case_type   tbl [16] = '{
    '{7'h14, 32'h3b0, 1'b1}, '{7'h14, 32'h3bf, 1'b0},
    '{7'h16, 32'h3df, 1'b1}, '{7'h1d, 32'h3c0, 1'b0},
    '{7'h14, 32'h103c0, 1'b0}, '{7'h54, 32'h3c0, 1'b1},
    '{7'h10, 32'ha0000, 1'b1}, '{7'h45, 32'h3c0, 1'b0},
    '{7'h05, 32'h3c0, 1'b1}, '{7'h26, 32'h3c6, 1'b1},
    '{7'h26, 32'h3c8, 1'b1}, '{7'h26, 32'h3c9, 1'b1},
    '{7'h2f, 32'h3c6, 1'b0}, '{7'h25, 32'h3c8, 1'b0},
    '{7'h2c, 32'h3c9, 1'b1}, '{7'h34, 32'h3c6, 1'b1}};

  pbvto_core i_pbvto_core (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .req_start_i(req_start_i), .req_addr_i(req_addr_i), .req_io_i(req_io_i),
    .req_write_i(req_write_i), .req_post_i(req_post_i), .req_mwi_i(req_mwi_i),
    .req_own_cfg_i(req_own_cfg_i), .base_limit_hit_i(base_limit_hit_i), .xfer_done_i(xfer_done_i),
    .tgt_gnt_i(tgt_gnt_i), .tgt_started_i(tgt_started_i), .tgt_data_phase_i(tgt_data_phase_i),
    .tgt_xfer_i(tgt_xfer_i), .line_boundary_i(line_boundary_i), .ini_last_dword_i(ini_last_dword_i),
    .ini_end_i(ini_end_i), .wbuf_full_i(wbuf_full_i), .tgt_idle_i(tgt_idle_i),
    .dat_valid_i(dat_valid_i), .dat_i(dat_i), .be_i(be_i), .fwd_o(fwd_o), .retry_o(retry_o),
    .disc_o(disc_o), .tgt_req_o(tgt_req_o), .frame_drop_o(frame_drop_o), .dat_valid_o(dat_valid_o),
    .dat_o(dat_o), .be_o(be_o));
  pbvto_far i_pbvto_far (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .req_i(tgt_req_o),
    .stall_i(stall), .gnt_o(tgt_gnt_i), .started_o(tgt_started_i), .phase_o(tgt_data_phase_i),
    .xfer_o(tgt_xfer_i), .line_o(line_boundary_i), .idle_o(tgt_idle_i));

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk_i);
  endtask
  task automatic chk(input logic [35:0] seen, input logic [35:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    tick(1);
    reg_wr_i <= 1'b0;
    tick(1);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    rq.push_back(e);
    tick(1);
    reg_rd_i <= 1'b0;
    tick(1);
  endtask
  task automatic set(input logic s, input logic [31:0] a, input logic io, w, p, h);
    req_addr_i[s] <= a;
    req_io_i[s] <= io;
    req_write_i[s] <= w;
    req_post_i[s] <= p;
    base_limit_hit_i[s] <= h;
  endtask
  // e holds the awaited fwd_o and retry_o bits, side 1 first
  task automatic go(input logic [1:0] s, input logic [3:0] e);
    req_start_i <= s;
    sq.push_back(e);
    tick(1);
    req_start_i <= '0;
    tick(1);
  endtask
  task automatic free(input logic [1:0] s);
    xfer_done_i <= s;
    tick(1);
    xfer_done_i <= '0;
    tick(2);
  endtask
  task automatic watch(input int n);
    seen3 = '0;
    repeat (n)
    begin
      tick(1);
      seen3 |= {disc_o[0], frame_drop_o[1], retry_o[0]};
    end
  endtask

  initial
    forever #5 sys_clk_i = ~sys_clk_i;
  always @(posedge sys_clk_i)
  begin
    rd_d <= reg_rd_i;
    st_d <= |req_start_i;
    if (rd_d)
      chk(36'(reg_rdata_o), 36'(rq.pop_front()));
    if (st_d)
      chk(36'({fwd_o, retry_o}), 36'(sq.pop_front()));
    if (dat_valid_o[1])
      chk({be_o[1], dat_o[1]}, dq.pop_front());
    if (dat_valid_o[0])
      chk({be_o[0], dat_o[0]}, eq.pop_front());
  end
  initial
  begin
    #400000;
    n_errors++;
    summarize();
  end

  initial
  begin
    tick(5);
    resetn_i <= 1'b1;
    tick(3);
    for (int a = 0; a < 32; a += 4)
      rd(8'(a), 32'h0);
    wr(8'h14, 32'h7f);
    rd(8'h14, 32'h40);
    $display("test registers done");
    foreach (tbl[i])
    begin
      wr(8'h00, {29'h0, tbl[i].k[6:4]});
      v = tbl[i].a | {16'h0, 6'($random(seed)), 10'h0};
      set(tbl[i].k[3], v, tbl[i].k[2], tbl[i].k[1], 1'b0, tbl[i].k[0]);
      m = 2'b01 << tbl[i].k[3];
      go(m, {tbl[i].f ? m : 2'b00, 2'b00});
      tick(3);
      free(m);
    end
    $display("test decode done");
    repeat (3)
    begin
      v = $random(seed);
      b = 4'($random(seed));
      dat_valid_i <= 2'b11;
      dat_i[0] <= v;
      be_i[0] <= b;
      dat_i[1] <= ~v;
      be_i[1] <= ~b;
      dq.push_back({b, v});
      eq.push_back({~b, ~v});
      tick(1);
    end
    dat_valid_i <= 2'b00;
    tick(4);
    $display("test data done");
    wr(8'h00, 32'h0);
    set(1'b0, 32'h3c0, 1'b1, 1'b0, 1'b0, 1'b1);
    set(1'b1, 32'h3c0, 1'b1, 1'b0, 1'b0, 1'b1);
    go(2'b11, 4'b0110);
    go(2'b10, 4'b0010);
    free(2'b01);
    go(2'b10, 4'b1000);
    go(2'b01, 4'b0001);
    free(2'b10);
    set(1'b0, 32'h100, 1'b0, 1'b1, 1'b1, 1'b1);
    set(1'b1, 32'h100, 1'b0, 1'b1, 1'b1, 1'b1);
    go(2'b11, 4'b1100);
    free(2'b01);
    req_own_cfg_i <= 1'b1;
    go(2'b01, 4'b0100);
    req_own_cfg_i <= 1'b0;
    free(2'b11);
    $display("test ordering done");
    stall <= 2'b10;
    wr(8'h0c, 32'h3);
    set(1'b0, 32'h3c0, 1'b1, 1'b0, 1'b0, 1'b1);
    go(2'b01, 4'b0100);
    watch(20);
    chk(36'(seen3[0]), 36'h1);
    wr(8'h0c, 32'h0);
    go(2'b01, 4'b0100);
    watch(40);
    chk(36'(seen3[0]), 36'h0);
    stall <= 2'b00;
    tick(12);
    free(2'b01);
    wr(8'h14, 32'h2);
    go(2'b01, 4'b0100);
    watch(20);
    chk(36'(seen3[2:1]), 36'h3);
    free(2'b01);
    $display("test timers done");
    chk(36'(dq.size() + eq.size() + rq.size() + sq.size()), 36'h0);
    summarize();
  end
endmodule
`default_nettype wire
